// file: shared/pcs_pkg.sv
package pcs_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int PC_W       = 15;  // program counter width
    localparam int LATCH_W    = 7;   // upper program counter bits
    localparam int SP_W       = 5;   // stack pointer, one spare bit
    localparam int ENT_IDX_W  = 4;   // sixteen stack entries
    localparam int DEPTH      = 16;  // stack levels
    localparam int BYTE_W     = 8;   // register data width
    localparam int REG_IDX_W  = 12;  // register index width
    localparam int ADDR_LSB   = 2;   // word aligned, byte address = 4 * index
    localparam int CALL_OPD_W = 11;  // direct call operand width
    localparam int BRA_OPD_W  = 9;   // signed branch operand width
    localparam int LATCH_CALL_LSB = 3; // latch bits taken by a direct call

    // ------------------------------------------------------------
    // register indexes
    // ------------------------------------------------------------
    localparam logic [11:0] IDX_CTRL          = 12'hFE0;
    localparam logic [11:0] IDX_FLAGS         = 12'hFE1;
    localparam logic [11:0] IDX_PC_LOW        = 12'hFE2;
    localparam logic [11:0] IDX_PC_HIGH_LATCH = 12'hFE3;
    localparam logic [11:0] IDX_STACK_INDEX   = 12'hFED;
    localparam logic [11:0] IDX_TOS_LOW       = 12'hFEE;
    localparam logic [11:0] IDX_TOS_HIGH      = 12'hFEF;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CTRL_FAULT_EN_BIT = 0;  // stack fault reset enable
    localparam int FLAGS_OVF_BIT     = 0;  // overflow flag, write 1 clears
    localparam int FLAGS_UNF_BIT     = 1;  // underflow flag, write 1 clears

    // ------------------------------------------------------------
    // reset and marker values
    // ------------------------------------------------------------
    localparam logic [14:0] PC_RESET       = 15'h0000;
    localparam logic [6:0]  LATCH_RESET    = 7'h00;
    localparam logic [4:0]  SP_RESET       = 5'h1F;  // empty stack
    localparam logic [4:0]  SP_LAST_LEVEL  = 5'h0F;  // sixteenth level in use
    localparam logic        FAULT_EN_RESET = 1'b0;
    localparam logic [14:0] ENTRY_RESET    = 15'h0000;

    // ------------------------------------------------------------
    // operations signalled by the decoder and interrupt sequencer
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_NONE,
        OP_STEP,
        OP_PC_LOW_WRITE,
        OP_CALL_DIRECT,
        OP_CALL_VIA_WORKING_REG,
        OP_BRANCH_BY_WORKING_REG,
        OP_BRANCH_BY_IMMEDIATE,
        OP_RETURN,
        OP_RETURN_WITH_LITERAL,
        OP_RETURN_FROM_INTERRUPT,
        OP_IRQ_VECTOR
    } pcs_op_t;

endpackage

// file: rtl/pcs_stack_mem.sv
`timescale 1ns/1ps
// sixteen entry return store, byte lane writes, one read port
module pcs_stack_mem (
    input  logic        sys_clk_i,
    input  logic        rst_i,
    input  logic        wr_lo_i,    // write bits 7..0
    input  logic        wr_hi_i,    // write bits 14..8
    input  logic [3:0]  wr_idx_i,
    input  logic [14:0] wr_data_i,
    input  logic [3:0]  rd_idx_i,
    output logic [14:0] rd_data_o
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [pcs_pkg::DEPTH-1:0][pcs_pkg::PC_W-1:0] ent; // entries
    } pcs_mem_st_t;

    pcs_mem_st_t st_ff;   // registered store
    pcs_mem_st_t nxt_st;  // next store

    // ------------------------------------------------------------
    // write lanes
    // ------------------------------------------------------------
    // entries are cleared at reset so reads never show unknowns
    always_comb begin
        nxt_st = st_ff;
        if (wr_lo_i) begin
            nxt_st.ent[wr_idx_i][7:0] = wr_data_i[7:0];
        end
        if (wr_hi_i) begin
            nxt_st.ent[wr_idx_i][14:8] = wr_data_i[14:8];
        end
    end

    // register the store
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // read straight from the flops
    assign rd_data_o = st_ff.ent[rd_idx_i];

endmodule

// file: rtl/pcs_ahb_slave.sv
`timescale 1ns/1ps
// ahb-lite slave front end: writes take no wait, reads take one
module pcs_ahb_slave (
    input  logic        sys_clk_i,
    input  logic        rst_i,
    input  logic        hsel_i,
    input  logic [31:0] haddr_i,
    input  logic [1:0]  htrans_i,
    input  logic        hwrite_i,
    input  logic [2:0]  hsize_i,
    input  logic [31:0] hwdata_i,
    input  logic        hready_i,
    output logic        hreadyout_o,
    output logic        hresp_o,
    output logic [31:0] hrdata_o,
    output logic        reg_wr_o,     // one cycle, data phase of a write
    output logic [11:0] reg_idx_o,    // register index of the transfer
    output logic [7:0]  reg_wdata_o,
    input  logic [7:0]  reg_rdata_i   // read value for reg_idx_o
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum {PH_IDLE, PH_WRITE, PH_READ_WAIT, PH_READ_DONE} pcs_ph_t;

    typedef struct packed {
        pcs_ph_t     ph;     // data phase in progress
        logic [11:0] idx;    // captured register index
        logic [31:0] rdata;  // registered read data
    } pcs_ahb_st_t;

    pcs_ahb_st_t st_ff;
    pcs_ahb_st_t nxt_st;
    logic        accept;     // address phase taken this edge

    // hsize is not checked: only whole words are issued
    assign accept = hsel_i & htrans_i[1] & hready_i;

    // ------------------------------------------------------------
    // phase tracking
    // ------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        // the read wait lets a preceding write land before sampling
        if (st_ff.ph == PH_READ_WAIT) begin
            nxt_st.rdata = {24'h000000, reg_rdata_i};
            nxt_st.ph    = PH_READ_DONE;
        end else if (accept) begin
            nxt_st.idx = haddr_i[pcs_pkg::ADDR_LSB +: pcs_pkg::REG_IDX_W];
            nxt_st.ph  = hwrite_i ? PH_WRITE : PH_READ_WAIT;
        end else begin
            nxt_st.ph = PH_IDLE;
        end
    end

    // register the phase
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            st_ff <= '{ph: PH_IDLE, idx: 12'h000, rdata: 32'h00000000};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign hreadyout_o = (st_ff.ph != PH_READ_WAIT);
    assign hresp_o     = 1'b0;           // always okay
    assign hrdata_o    = st_ff.rdata;
    assign reg_wr_o    = (st_ff.ph == PH_WRITE);
    assign reg_idx_o   = st_ff.idx;
    assign reg_wdata_o = hwdata_i[7:0];  // upper lanes ignored

endmodule

// file: rtl/pcs_pc_stack.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// program counter loading and hardware return stack
// ------------------------------------------------------------
// Notes on behaviour
// - 15-bit pc, low byte register, latch supplies top
// - any reset clears the whole pc
// - pc low write also loads latch bits
// - direct call: operand low, latch 6..3 high
// - call via working reg: w low, latch high
// - w branch: pc plus one plus unsigned w
// - immediate branch: pc plus one plus signed operand
// - sixteen entry 15-bit private return stack
// - push on calls and irq, pop on returns
// - stack operations never touch the latch
// - fault reset off: stack wraps circularly
// - overflow and underflow flags always set
// - five bit pointer marks most recent entry
// - pointer selects entry seen through tos pair
// - push: bump then store; pop: load then drop
// - reset leaves stack empty, pointer 0x1F
// - empty, fault reset off: tos shows entry 0x0F
// - fault reset on: fault resets and flags
module pcs_pc_stack (
    input  logic             sys_clk_i,
    input  logic             rst_i,
    input  pcs_pkg::pcs_op_t op_i,          // operation this cycle
    input  logic [10:0]      operand_i,     // call or branch operand
    input  logic [7:0]       wreg_i,        // working register
    input  logic [7:0]       pcl_data_i,    // result written to pc low
    input  logic [14:0]      irq_vector_i,  // interrupt entry address
    input  logic             hsel_i,
    input  logic [31:0]      haddr_i,
    input  logic [1:0]       htrans_i,
    input  logic             hwrite_i,
    input  logic [2:0]       hsize_i,
    input  logic [31:0]      hwdata_i,
    input  logic             hready_i,
    output logic             hreadyout_o,
    output logic             hresp_o,
    output logic [31:0]      hrdata_o,
    output logic [14:0]      pc_o,               // current fetch address
    output logic             stack_fault_reset_o // one cycle reset request
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [14:0] pc;          // program counter
        logic [6:0]  latch;       // pc_high_latch
        logic [4:0]  sp;          // stack_index
        logic        fault_en;    // stack_fault_reset_enable
        logic        ovf;         // stack_overflow_flag
        logic        unf;         // stack_underflow_flag
        logic        fault_pulse; // reset request
    } pcs_core_st_t;

    pcs_core_st_t st_ff;   // registered state
    pcs_core_st_t nxt_st;  // next state

    // register bus side
    logic        reg_wr;     // write strobe from the slave
    logic [11:0] reg_idx;    // register index in the data phase
    logic [7:0]  reg_wdata;  // write byte
    logic [7:0]  reg_rdata;  // read byte for reg_idx

    // stack store side
    logic        mem_wr_lo;  // write low lane
    logic        mem_wr_hi;  // write high lane
    logic [3:0]  mem_wr_idx; // entry written
    logic [14:0] mem_wr_data;
    logic [14:0] tos;        // entry under the pointer

    // decoded operation
    logic        push;       // calls and interrupt entry
    logic        pop;        // all returns
    logic        ovf_evt;    // push beyond sixteenth level
    logic        unf_evt;    // pop below first level
    logic        fault;      // fault with reset enabled
    logic [14:0] pc_inc;     // address of the next instruction
    logic [4:0]  sp_up;
    logic [4:0]  sp_dn;
    logic [14:0] tos_view;   // what the tos pair shows
    logic        sw_wr_tos_lo;
    logic        sw_wr_tos_hi;

    // ------------------------------------------------------------
    // register bus slave
    // ------------------------------------------------------------
    pcs_ahb_slave i_pcs_ahb_slave (
        .sys_clk_i   (sys_clk_i),
        .rst_i       (rst_i),
        .hsel_i      (hsel_i),
        .haddr_i     (haddr_i),
        .htrans_i    (htrans_i),
        .hwrite_i    (hwrite_i),
        .hsize_i     (hsize_i),
        .hwdata_i    (hwdata_i),
        .hready_i    (hready_i),
        .hreadyout_o (hreadyout_o),
        .hresp_o     (hresp_o),
        .hrdata_o    (hrdata_o),
        .reg_wr_o    (reg_wr),
        .reg_idx_o   (reg_idx),
        .reg_wdata_o (reg_wdata),
        .reg_rdata_i (reg_rdata)
    );

    // ------------------------------------------------------------
    // return stack store
    // ------------------------------------------------------------
    // kept apart from any program or data memory
    pcs_stack_mem i_pcs_stack_mem (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .wr_lo_i   (mem_wr_lo),
        .wr_hi_i   (mem_wr_hi),
        .wr_idx_i  (mem_wr_idx),
        .wr_data_i (mem_wr_data),
        .rd_idx_i  (st_ff.sp[3:0]),
        .rd_data_o (tos)
    );

    // ------------------------------------------------------------
    // operation decode
    // ------------------------------------------------------------
    assign push = (op_i == pcs_pkg::OP_CALL_DIRECT)
                | (op_i == pcs_pkg::OP_CALL_VIA_WORKING_REG)
                | (op_i == pcs_pkg::OP_IRQ_VECTOR);
    assign pop  = (op_i == pcs_pkg::OP_RETURN)
                | (op_i == pcs_pkg::OP_RETURN_WITH_LITERAL)
                | (op_i == pcs_pkg::OP_RETURN_FROM_INTERRUPT);

    // the pointer has one spare bit so faults can be seen
    assign sp_up   = st_ff.sp + 5'h01;
    assign sp_dn   = st_ff.sp - 5'h01;
    assign ovf_evt = push & (st_ff.sp == pcs_pkg::SP_LAST_LEVEL);
    assign unf_evt = pop & (st_ff.sp == pcs_pkg::SP_RESET);
    assign fault   = (ovf_evt | unf_evt) & st_ff.fault_en;
    assign pc_inc  = st_ff.pc + 15'h0001;

    // software tos writes only land when no push uses the store
    assign sw_wr_tos_lo = reg_wr & (reg_idx == pcs_pkg::IDX_TOS_LOW) & ~push;
    assign sw_wr_tos_hi = reg_wr & (reg_idx == pcs_pkg::IDX_TOS_HIGH) & ~push;

    // ------------------------------------------------------------
    // store write port
    // ------------------------------------------------------------
    // a push bumps the pointer and writes at the new index in one
    // edge, so the entry is stored under the incremented pointer
    always_comb begin
        mem_wr_lo   = 1'b0;
        mem_wr_hi   = 1'b0;
        mem_wr_idx  = st_ff.sp[3:0];
        mem_wr_data = pcs_pkg::ENTRY_RESET;
        if (push & ~fault) begin
            // wrap is free: only the low four bits index the store
            mem_wr_lo   = 1'b1;
            mem_wr_hi   = 1'b1;
            mem_wr_idx  = sp_up[3:0];
            // interrupt entry saves the instruction not yet run
            if (op_i == pcs_pkg::OP_IRQ_VECTOR) begin
                mem_wr_data = st_ff.pc;
            end else begin
                mem_wr_data = pc_inc;
            end
        end else if (sw_wr_tos_lo) begin
            mem_wr_lo   = 1'b1;
            mem_wr_data = {7'h00, reg_wdata};
        end else if (sw_wr_tos_hi) begin
            mem_wr_hi   = 1'b1;
            mem_wr_data = {reg_wdata[6:0], 8'h00};
        end
    end

    // ------------------------------------------------------------
    // top of stack view
    // ------------------------------------------------------------
    // an empty stack with fault reset on reads as zero
    always_comb begin
        if (st_ff.fault_en & (st_ff.sp == pcs_pkg::SP_RESET)) begin
            tos_view = pcs_pkg::ENTRY_RESET;
        end else begin
            tos_view = tos;
        end
    end

    // ------------------------------------------------------------
    // register read mux
    // ------------------------------------------------------------
    // unmapped indexes read zero
    always_comb begin
        reg_rdata = 8'h00;
        unique case (reg_idx)
            pcs_pkg::IDX_CTRL: begin
                reg_rdata[pcs_pkg::CTRL_FAULT_EN_BIT] = st_ff.fault_en;
            end
            pcs_pkg::IDX_FLAGS: begin
                reg_rdata[pcs_pkg::FLAGS_OVF_BIT] = st_ff.ovf;
                reg_rdata[pcs_pkg::FLAGS_UNF_BIT] = st_ff.unf;
            end
            pcs_pkg::IDX_PC_LOW: begin
                reg_rdata = st_ff.pc[7:0];
            end
            pcs_pkg::IDX_PC_HIGH_LATCH: begin
                reg_rdata = {1'b0, st_ff.latch};
            end
            pcs_pkg::IDX_STACK_INDEX: begin
                reg_rdata = {3'b000, st_ff.sp};
            end
            pcs_pkg::IDX_TOS_LOW: begin
                reg_rdata = tos_view[7:0];
            end
            pcs_pkg::IDX_TOS_HIGH: begin
                reg_rdata = {1'b0, tos_view[14:8]};
            end
            default: begin
                reg_rdata = 8'h00;
            end
        endcase
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_st             = st_ff;
        nxt_st.fault_pulse = 1'b0;

        // program counter loading per operation
        unique case (op_i)
            pcs_pkg::OP_NONE: begin
                // stall: pc holds
                nxt_st.pc = st_ff.pc;
            end
            pcs_pkg::OP_STEP: begin
                nxt_st.pc = pc_inc;
            end
            pcs_pkg::OP_PC_LOW_WRITE: begin
                nxt_st.pc = {st_ff.latch, pcl_data_i};
            end
            pcs_pkg::OP_CALL_DIRECT: begin
                nxt_st.pc = {st_ff.latch[6:pcs_pkg::LATCH_CALL_LSB],
                             operand_i};
            end
            pcs_pkg::OP_CALL_VIA_WORKING_REG: begin
                nxt_st.pc = {st_ff.latch, wreg_i};
            end
            pcs_pkg::OP_BRANCH_BY_WORKING_REG: begin
                nxt_st.pc = pc_inc + {7'h00, wreg_i};
            end
            pcs_pkg::OP_BRANCH_BY_IMMEDIATE: begin
                // full width add: 256-byte blocks are crossed freely
                nxt_st.pc = pc_inc
                          + {{6{operand_i[8]}}, operand_i[8:0]};
            end
            pcs_pkg::OP_RETURN,
            pcs_pkg::OP_RETURN_WITH_LITERAL,
            pcs_pkg::OP_RETURN_FROM_INTERRUPT: begin
                nxt_st.pc = tos;
            end
            pcs_pkg::OP_IRQ_VECTOR: begin
                nxt_st.pc = irq_vector_i;
            end
            default: begin
                nxt_st.pc = st_ff.pc;
            end
        endcase

        // pointer: hardware moves win over a software write
        if (push) begin
            nxt_st.sp = sp_up;
        end else if (pop) begin
            nxt_st.sp = sp_dn;
        end else if (reg_wr & (reg_idx == pcs_pkg::IDX_STACK_INDEX)) begin
            // a write racing an interrupt push loses, so software
            // should mask interrupts around pointer updates
            nxt_st.sp = reg_wdata[4:0];
        end

        // software write to pc low behaves like the instruction form
        if ((op_i == pcs_pkg::OP_NONE) & reg_wr
                & (reg_idx == pcs_pkg::IDX_PC_LOW)) begin
            nxt_st.pc = {st_ff.latch, reg_wdata};
        end

        // latch: only the bus writes it, never a push or pop
        if (reg_wr & (reg_idx == pcs_pkg::IDX_PC_HIGH_LATCH)) begin
            nxt_st.latch = reg_wdata[6:0];
        end

        // configuration
        if (reg_wr & (reg_idx == pcs_pkg::IDX_CTRL)) begin
            nxt_st.fault_en = reg_wdata[pcs_pkg::CTRL_FAULT_EN_BIT];
        end

        // flags: write one clears, a new event wins the same cycle
        if (reg_wr & (reg_idx == pcs_pkg::IDX_FLAGS)) begin
            nxt_st.ovf = st_ff.ovf & ~reg_wdata[pcs_pkg::FLAGS_OVF_BIT];
            nxt_st.unf = st_ff.unf & ~reg_wdata[pcs_pkg::FLAGS_UNF_BIT];
        end
        if (ovf_evt) begin
            nxt_st.ovf = 1'b1;
        end
        if (unf_evt) begin
            nxt_st.unf = 1'b1;
        end

        // fault reset: pc and pointer return to reset values, the
        // flags survive so software can see why it restarted
        if (fault) begin
            nxt_st.pc          = pcs_pkg::PC_RESET;
            nxt_st.sp          = pcs_pkg::SP_RESET;
            nxt_st.fault_pulse = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            st_ff <= '{pc:          pcs_pkg::PC_RESET,
                       latch:       pcs_pkg::LATCH_RESET,
                       sp:          pcs_pkg::SP_RESET,
                       fault_en:    pcs_pkg::FAULT_EN_RESET,
                       ovf:         1'b0,
                       unf:         1'b0,
                       fault_pulse: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign pc_o                = st_ff.pc;
    assign stack_fault_reset_o = st_ff.fault_pulse;

endmodule

// file: test/pcs_sva.sv
`timescale 1ns/1ps
// pc port checks against reset and the decoder's operation, plus hresp and fault pulse checks
module pcs_sva (
    input logic             sys_clk_i,
    input logic             rst_i,
    input pcs_pkg::pcs_op_t op_i,
    input logic [10:0]      operand_i,
    input logic [7:0]       wreg_i,
    input logic             hresp_o,
    input logic [14:0]      pc_o,
    input logic             stack_fault_reset_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    chk_reset_pc:
    assert property (disable iff (1'b0) rst_i |=> pc_o == 15'h0000) else $error("pc kept");
    chk_step_pc:
    assert property (op_i == pcs_pkg::OP_STEP |=> pc_o == $past(pc_o) + 15'h0001)
        else $error("step bad");
    chk_wreg_branch:
    assert property (op_i == pcs_pkg::OP_BRANCH_BY_WORKING_REG
        |=> pc_o == $past(pc_o) + 15'h0001 + $past(wreg_i)) else $error("brw bad");
    chk_imm_branch:
    assert property (op_i == pcs_pkg::OP_BRANCH_BY_IMMEDIATE |=> pc_o == $past(pc_o)
        + 15'h0001 + {{6{$past(operand_i[8])}}, $past(operand_i[8:0])}) else $error("bra bad");
    // an overflow with fault reset on sends pc to zero instead
    chk_call_low:
    assert property (op_i == pcs_pkg::OP_CALL_DIRECT
        |=> stack_fault_reset_o || pc_o[10:0] == $past(operand_i)) else $error("call bad");
    chk_call_via_working_reg_low:
    assert property (op_i == pcs_pkg::OP_CALL_VIA_WORKING_REG
        |=> stack_fault_reset_o || pc_o[7:0] == $past(wreg_i)) else $error("call_via_working_reg bad");
    chk_resp_okay:
    assert property (hresp_o == 1'b0) else $error("resp bad");
    chk_fault_pulse:
    assert property (stack_fault_reset_o |=> !stack_fault_reset_o) else $error("long pulse");
endmodule

// file: test/pcs_dec_model.sv
`timescale 1ns/1ps
// decoder stand-in: one operation per call, stall in between
module pcs_dec_model (
    input  logic             sys_clk_i,
    output pcs_pkg::pcs_op_t op_o,
    output logic [10:0]      operand_o,
    output logic [7:0]       wreg_o
);
    initial op_o = pcs_pkg::OP_NONE;
    initial operand_o = 11'h000;
    initial wreg_o = 8'h00;
    task automatic issue(input pcs_pkg::pcs_op_t o, input logic [10:0] a, input logic [7:0] w);
        @(posedge sys_clk_i);
        op_o <= o;
        operand_o <= a;
        wreg_o <= w;
        @(posedge sys_clk_i);
        op_o <= pcs_pkg::OP_NONE;
    endtask
endmodule

// file: test/tb_program_counter_and_call_stack.sv
`timescale 1ns/1ps
module tb_program_counter_and_call_stack;
    logic sys_clk_i = 1'b0, rst_i = 1'b1, hwrite_i = 1'b0, seen = 1'b0, hrdy, hresp_o, flt;
    logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o;
    logic [1:0] htrans_i = 2'h0;
    logic [14:0] pc_o;
    logic [10:0] opd;
    logic [7:0] w, r;
    pcs_pkg::pcs_op_t op;
    int err_count = 0, checks = 0;
    always #50 sys_clk_i = ~sys_clk_i;
    // fault request is one cycle wide, so keep it sticky
    always @(posedge sys_clk_i) if (flt) seen <= 1'b1;
    pcs_dec_model i_pcs_dec_model (.sys_clk_i(sys_clk_i), .op_o(op), .operand_o(opd),
        .wreg_o(w));
    pcs_pc_stack i_pcs_pc_stack (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .op_i(op),
        .operand_i(opd), .wreg_i(w), .pcl_data_i(w), .irq_vector_i(15'h7ABC), .hsel_i(1'b1),
        .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2),
        .hwdata_i(hwdata_i), .hready_i(hrdy), .hreadyout_o(hrdy), .hresp_o(hresp_o),
        .hrdata_o(hrdata_o), .pc_o(pc_o), .stack_fault_reset_o(flt));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task end_sim;
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // single ahb-lite transfer, waits on hready in both phases
    task bus(input logic wr, input logic [11:0] idx, input logic [7:0] d);
        @(posedge sys_clk_i);
        haddr_i <= {18'h0, idx, 2'h0};
        htrans_i <= 2'h2;
        hwrite_i <= wr;
        @(posedge sys_clk_i iff hrdy);
        htrans_i <= 2'h0;
        hwdata_i <= {24'h0, d};
        @(posedge sys_clk_i iff hrdy);
        r = hrdata_o[7:0];
    endtask
    task rd(input logic [11:0] idx, input logic [7:0] e);
        bus(1'b0, idx, 8'h00);
        chk(r, e);
    endtask
    task opc(input pcs_pkg::pcs_op_t o, input logic [10:0] a, input logic [7:0] v,
        input logic [14:0] e);
        i_pcs_dec_model.issue(o, a, v);
        #1 chk(pc_o, e);
    endtask
    task t_fault;
        bus(1'b1, 12'hFE0, 8'h01);
        // a non-zero entry 0x0F shows whether the fault really cleared pc
        bus(1'b1, 12'hFEE, 8'h77);
        rd(12'hFEE, 8'h00);
        opc(pcs_pkg::OP_RETURN, 11'h0, 8'h0, 15'h0000);
        repeat (2) @(posedge sys_clk_i);
        chk(seen, 1'b1);
        rd(12'hFE1, 8'h02);
        bus(1'b1, 12'hFE0, 8'h00);
        rd(12'hFEE, 8'h77);
        bus(1'b1, 12'hFE1, 8'h03);
    endtask
    task t_flow;
        bus(1'b1, 12'hFE3, 8'h55);
        opc(pcs_pkg::OP_STEP, 11'h0, 8'h0, 15'h0001);
        opc(pcs_pkg::OP_CALL_DIRECT, 11'h123, 8'h0, 15'h5123);
        rd(12'hFED, 8'h00);
        rd(12'hFEE, 8'h02);
        opc(pcs_pkg::OP_CALL_VIA_WORKING_REG, 11'h0, 8'h34, 15'h5534);
        rd(12'hFE3, 8'h55);
        opc(pcs_pkg::OP_RETURN_WITH_LITERAL, 11'h0, 8'h0, 15'h5124);
        opc(pcs_pkg::OP_BRANCH_BY_IMMEDIATE, 11'h1FE, 8'h0, 15'h5123);
        opc(pcs_pkg::OP_BRANCH_BY_WORKING_REG, 11'h0, 8'hFF, 15'h5223);
        opc(pcs_pkg::OP_PC_LOW_WRITE, 11'h0, 8'h12, 15'h5512);
        opc(pcs_pkg::OP_IRQ_VECTOR, 11'h0, 8'h0, 15'h7ABC);
        opc(pcs_pkg::OP_RETURN_FROM_INTERRUPT, 11'h0, 8'h0, 15'h5512);
        bus(1'b1, 12'hFEE, 8'h77);
        opc(pcs_pkg::OP_RETURN, 11'h0, 8'h0, 15'h0077);
        // software selects entry 1 through the pointer, then restores it
        bus(1'b1, 12'hFED, 8'h01);
        rd(12'hFEF, 8'h55);
        rd(12'hFE2, 8'h77);
        bus(1'b1, 12'hFE2, 8'h34);
        #1 chk(pc_o, 15'h5534);
        bus(1'b1, 12'hFED, 8'h1F);
    endtask
    // seventeenth push lands on the first entry
    task t_wrap;
        for (int k = 0; k < 17; k++) i_pcs_dec_model.issue(pcs_pkg::OP_CALL_DIRECT, 11'(k), 8'h0);
        rd(12'hFE1, 8'h01);
        opc(pcs_pkg::OP_RETURN, 11'h0, 8'h0, 15'h5010);
        opc(pcs_pkg::OP_RETURN, 11'h0, 8'h0, 15'h500F);
    endtask
    initial begin
        repeat (5) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        #1 chk(pc_o, 15'h0000);
        rd(12'hFED, 8'h1F);
        rd(12'h000, 8'h00);
        t_fault;
        t_flow;
        t_wrap;
        end_sim;
    end
    initial begin
        #200000;
        err_count++;
        end_sim;
    end
endmodule
bind pcs_pc_stack pcs_sva i_pcs_sva (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .op_i(op_i),
    .operand_i(operand_i), .wreg_i(wreg_i), .hresp_o(hresp_o), .pc_o(pc_o),
    .stack_fault_reset_o(stack_fault_reset_o));
